// ### hdl/eee_global_indirect_regs.sv
`timescale 1ns/100ps

// Contract
// - offset at 0x6f, data byte at 0xa0
// - diagnostic bits 15:4 read 0x6,0x8,0x0
// - bit 3 port 4 next-page enable, reset 1
// - cleared enable skips next-page exchange
// - minimum lpi register reads all zero
// - wake threshold reads fixed 0x0201
// - wake over threshold bumps error counter
module eee_global_indirect_regs
  import eee_pkg::*;
(
  input  wire logic                     clk_in,
  input  wire logic                     rstn_in,
  input  wire eee_req_t                 req_in,
  input  wire eee_wake_t                wake_in,
  output logic [7:0]                    rdata_out,
  output logic                          rvalid_out,
  output logic [EEE_NUM_PORTS-1:0]      np_exchange_en_out,
  output logic [EEE_CNT_W-1:0]          wake_err_cnt_out
);

  eee_state_t st_reg;
  eee_state_t st_next;
  logic       sel_global;

  assign sel_global = eee_is_global(st_reg.tbl_sel);

  // next state: register writes, read capture and wake error counting
  always_comb begin
    st_next        = st_reg;
    st_next.rvalid = 1'b0;
    // writes; the table only answers when the global eee group is selected
    if (req_in.wr) begin
      case (req_in.addr)
        EEE_ADDR_TBL_SEL: st_next.tbl_sel = req_in.wdata;
        EEE_ADDR_OFFSET:  st_next.offset  = req_in.wdata;
        EEE_ADDR_DATA: begin
          // only the low diagnostic byte holds writable bits
          if (sel_global && st_reg.offset == EEE_OFS_DIAG_LO) begin
            st_next.np_en = req_in.wdata[EEE_NUM_PORTS-1:0];
          end
        end
        default: ;
      endcase
    end
    // reads see the state before a same-cycle write
    if (req_in.rd) begin
      st_next.rvalid = 1'b1;
      case (req_in.addr)
        EEE_ADDR_TBL_SEL: st_next.rdata = st_reg.tbl_sel;
        EEE_ADDR_OFFSET:  st_next.rdata = st_reg.offset;
        EEE_ADDR_DATA:    st_next.rdata = sel_global ?
                            eee_byte(st_reg.offset, st_reg.np_en) : 8'h00;
        default:          st_next.rdata = 8'h00;
      endcase
    end
    // saturate rather than wrap so a flood of errors never reads as few
    if (wake_in.done && wake_in.dur > EEE_WAKE_THR_VAL && st_reg.wake_err != '1) begin
      st_next.wake_err = st_reg.wake_err + {{(EEE_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // single state register
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= EEE_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign rdata_out          = st_reg.rdata;
  assign rvalid_out         = st_reg.rvalid;
  assign np_exchange_en_out = st_reg.np_en;
  assign wake_err_cnt_out   = st_reg.wake_err;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  // data-port read with the global group and a given offset selected
  function automatic logic rd_at(input eee_req_t r, input logic sg,
                                 input logic [7:0] cur, input logic [7:0] want);
    return r.rd && r.addr == EEE_ADDR_DATA && sg && cur == want;
  endfunction : rd_at

  // the host spaces requests by an idle cycle, so the readback lands three cycles after the write
  property p_offset_readback;
    req_in.wr && req_in.addr == EEE_ADDR_OFFSET && !req_in.rd ##1 !req_in.wr ##1
      req_in.rd && req_in.addr == EEE_ADDR_OFFSET && !req_in.wr
      |=> rvalid_out && rdata_out == $past(req_in.wdata, 3);
  endproperty
  a_offset_readback: assert property (p_offset_readback)
    else $error("offset register did not read back");

  property p_diag_high;
    rd_at(req_in, sel_global, st_reg.offset, EEE_OFS_DIAG) |=> rdata_out == 8'h68;
  endproperty
  a_diag_high: assert property (p_diag_high)
    else $error("diagnostic high byte wrong");

  property p_diag_low;
    rd_at(req_in, sel_global, st_reg.offset, EEE_OFS_DIAG_LO)
      |=> rdata_out == {4'h0, $past(np_exchange_en_out)};
  endproperty
  a_diag_low: assert property (p_diag_low)
    else $error("diagnostic low byte wrong");

  property p_p4_write;
    req_in.wr && req_in.addr == EEE_ADDR_DATA && sel_global &&
      st_reg.offset == EEE_OFS_DIAG_LO
      |=> np_exchange_en_out[3] == $past(req_in.wdata[3]);
  endproperty
  a_p4_write: assert property (p_p4_write)
    else $error("port 4 next-page enable not written");

  property p_np_hold;
    !(req_in.wr && req_in.addr == EEE_ADDR_DATA) |=> $stable(np_exchange_en_out);
  endproperty
  a_np_hold: assert property (p_np_hold)
    else $error("next-page enable changed without a data write");

  property p_p31_write;
    req_in.wr && req_in.addr == EEE_ADDR_DATA && sel_global &&
      st_reg.offset == EEE_OFS_DIAG_LO
      |=> np_exchange_en_out[2:0] == $past(req_in.wdata[2:0]);
  endproperty
  a_p31_write: assert property (p_p31_write)
    else $error("ports 3..1 next-page enable not written");

  property p_min_lpi;
    rd_at(req_in, sel_global, st_reg.offset, EEE_OFS_MIN_LPI) ##1 1'b1
      |-> rvalid_out && rdata_out == 8'h00;
  endproperty
  a_min_lpi: assert property (p_min_lpi)
    else $error("minimum lpi register not zero");

  property p_wake_thr;
    rd_at(req_in, sel_global, st_reg.offset, EEE_OFS_WAKE_THR)
      |=> rvalid_out && rdata_out == 8'h02;
  endproperty
  a_wake_thr: assert property (p_wake_thr)
    else $error("wake threshold high byte wrong");

  property p_wake_count;
    wake_in.done && wake_in.dur > 16'h0201 && wake_err_cnt_out != 16'hffff
      |=> wake_err_cnt_out == $past(wake_err_cnt_out) + 16'h0001;
  endproperty
  a_wake_count: assert property (p_wake_count)
    else $error("wake error not counted");

  property p_wake_quiet;
    !(wake_in.done && wake_in.dur > 16'h0201) |=> $stable(wake_err_cnt_out);
  endproperty
  a_wake_quiet: assert property (p_wake_quiet)
    else $error("wake error counter moved without cause");

  // low bytes of the fixed registers; a wrong byte pairing shows here first
  property p_min_lpi_lo;
    rd_at(req_in, sel_global, st_reg.offset, EEE_OFS_MIN_LPI | 8'h01)
      |=> rvalid_out && rdata_out == 8'h00;
  endproperty
  a_min_lpi_lo: assert property (p_min_lpi_lo)
    else $error("minimum lpi low byte not zero");

  property p_wake_thr_lo;
    rd_at(req_in, sel_global, st_reg.offset, EEE_OFS_WAKE_THR | 8'h01)
      |=> rvalid_out && rdata_out == 8'h01;
  endproperty
  a_wake_thr_lo: assert property (p_wake_thr_lo)
    else $error("wake threshold low byte wrong");

  property p_diag_ctrl_lo;
    rd_at(req_in, sel_global, st_reg.offset, EEE_OFS_DIAG_CTRL | 8'h01)
      |=> rvalid_out && rdata_out == 8'h01;
  endproperty
  a_diag_ctrl_lo: assert property (p_diag_ctrl_lo)
    else $error("diagnostic control low byte wrong");

  // every read is answered one cycle later, and nothing else raises valid
  property p_rd_answer;
    req_in.rd |=> rvalid_out;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");

  property p_no_answer;
    !req_in.rd |=> !rvalid_out;
  endproperty
  a_no_answer: assert property (p_no_answer)
    else $error("valid without a read");

  // a data write anywhere but the enable byte of the global group is dropped
  property p_refused_write;
    req_in.wr && req_in.addr == EEE_ADDR_DATA &&
      !(sel_global && st_reg.offset == EEE_OFS_DIAG_LO) |=> $stable(np_exchange_en_out);
  endproperty
  a_refused_write: assert property (p_refused_write)
    else $error("next-page enable written through a refused path");

  // per-port or foreign tables must not leak global bytes
  property p_other_group_read;
    req_in.rd && req_in.addr == EEE_ADDR_DATA && !sel_global |=> rdata_out == 8'h00;
  endproperty
  a_other_group_read: assert property (p_other_group_read)
    else $error("global byte read with another group selected");

  // the select byte is kept whole, so software can read back what it wrote
  property p_tbl_readback;
    req_in.wr && req_in.addr == EEE_ADDR_TBL_SEL && !req_in.rd ##1 !req_in.wr ##1
      req_in.rd && req_in.addr == EEE_ADDR_TBL_SEL && !req_in.wr
      |=> rvalid_out && rdata_out == $past(req_in.wdata, 3);
  endproperty
  a_tbl_readback: assert property (p_tbl_readback)
    else $error("table select did not read back");

  c_diag_read: cover property (rd_at(req_in, sel_global, st_reg.offset, EEE_OFS_DIAG));
  c_np_clear:  cover property (np_exchange_en_out[3] ##1 !np_exchange_en_out[3]);
  c_wake_err:  cover property (wake_in.done && wake_in.dur > 16'h0201);
  // refused data writes and threshold reads are the paths software rarely takes
  c_refused_wr: cover property (req_in.wr && req_in.addr == EEE_ADDR_DATA && !sel_global);
  c_thr_read:   cover property (rd_at(req_in, sel_global, st_reg.offset, EEE_OFS_WAKE_THR));

endmodule : eee_global_indirect_regs

// ### shared/eee_pkg.sv
package eee_pkg;

  // direct addresses on the switch register port
  localparam logic [7:0]  EEE_ADDR_TBL_SEL   = 8'h6e;
  localparam logic [7:0]  EEE_ADDR_OFFSET    = 8'h6f;
  localparam logic [7:0]  EEE_ADDR_DATA      = 8'ha0;

  // table-select fields: bits 7..5 pick the table, bits 3..0 the group
  localparam int          EEE_TBL_HI         = 7;
  localparam int          EEE_TBL_LO         = 5;
  localparam int          EEE_GRP_HI         = 3;
  localparam int          EEE_GRP_LO         = 0;
  localparam logic [2:0]  EEE_TBL_EEE        = 3'h1;
  localparam logic [3:0]  EEE_GRP_GLOBAL     = 4'h0;

  // indirect byte offsets of the global group (even byte = high half)
  localparam logic [7:0]  EEE_OFS_DIAG       = 8'h34;
  localparam logic [7:0]  EEE_OFS_DIAG_LO    = 8'h35;
  localparam logic [7:0]  EEE_OFS_MIN_LPI    = 8'h36;
  localparam logic [7:0]  EEE_OFS_WAKE_THR   = 8'h38;
  localparam logic [7:0]  EEE_OFS_DIAG_CTRL  = 8'h3a;

  // fixed and reset values
  localparam logic [3:0]  EEE_DIAG_RSVD_HI   = 4'h6;
  localparam logic [3:0]  EEE_DIAG_RSVD_MID  = 4'h8;
  localparam logic [3:0]  EEE_DIAG_RSVD_LO   = 4'h0;
  localparam int          EEE_NUM_PORTS      = 4;
  localparam logic [3:0]  EEE_NP_EN_RST      = 4'hf;
  localparam logic [15:0] EEE_MIN_LPI_VAL    = 16'h0000;
  localparam logic [15:0] EEE_WAKE_THR_VAL   = 16'h0201;
  localparam logic [15:0] EEE_DIAG_CTRL_VAL  = 16'h0001;
  localparam int          EEE_CNT_W          = 16;
  localparam logic [7:0]  EEE_BYTE_RST       = 8'h00;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eee_req_t;

  typedef struct packed {
    logic        done;
    logic [15:0] dur;
  } eee_wake_t;

  typedef struct packed {
    logic [7:0]                 tbl_sel;
    logic [7:0]                 offset;
    logic [EEE_NUM_PORTS-1:0]   np_en;
    logic [EEE_CNT_W-1:0]       wake_err;
    logic [7:0]                 rdata;
    logic                       rvalid;
  } eee_state_t;

  localparam eee_state_t EEE_STATE_RST = '{
    tbl_sel: EEE_BYTE_RST, offset: EEE_BYTE_RST, np_en: EEE_NP_EN_RST,
    wake_err: '0, rdata: EEE_BYTE_RST, rvalid: 1'b0};

  // true when the table select points at the global eee group
  function automatic logic eee_is_global(input logic [7:0] sel);
    return (sel[EEE_TBL_HI:EEE_TBL_LO] == EEE_TBL_EEE) &&
           (sel[EEE_GRP_HI:EEE_GRP_LO] == EEE_GRP_GLOBAL);
  endfunction : eee_is_global

  // byte view of the global group; unmapped offsets read zero
  function automatic logic [7:0] eee_byte(input logic [7:0] ofs,
                                          input logic [EEE_NUM_PORTS-1:0] np);
    logic [15:0] word;
    word = 16'h0000;
    case ({ofs[7:1], 1'b0})
      EEE_OFS_DIAG:      word = {EEE_DIAG_RSVD_HI, EEE_DIAG_RSVD_MID, EEE_DIAG_RSVD_LO, np};
      EEE_OFS_MIN_LPI:   word = EEE_MIN_LPI_VAL;
      EEE_OFS_WAKE_THR:  word = EEE_WAKE_THR_VAL;
      EEE_OFS_DIAG_CTRL: word = EEE_DIAG_CTRL_VAL;
      default:           word = 16'h0000;
    endcase
    return ofs[0] ? word[7:0] : word[15:8];
  endfunction : eee_byte

endpackage : eee_pkg

// ### test/eee_host_model.sv
`timescale 1ns/100ps
// host side of the switch register port
module eee_host_model
  import eee_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in,
  output eee_req_t        req_out
);
  initial req_out = '0;
  // one request per call, then lines flip so stale values never look valid
  task automatic op(input logic w, input logic r, input logic [7:0] a,
                    input logic [7:0] d, output logic [7:0] q, output logic v);
    @(posedge clk_in);
    req_out <= '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge clk_in);
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1;
    q = rdata_in;
    v = rvalid_in;
  endtask : op
  // table select then offset; threshold is never meant to be rewritten
  task automatic sel(input logic [7:0] tbl, input logic [7:0] ofs);
    logic [7:0] q;
    logic       v;
    op(1'b1, 1'b0, EEE_ADDR_TBL_SEL, tbl, q, v);
    op(1'b1, 1'b0, EEE_ADDR_OFFSET, ofs, q, v);
  endtask : sel
endmodule : eee_host_model

// ### test/testbench.sv
`timescale 1ns/100ps
module testbench
  import eee_pkg::*;
;
  logic       clk_in = 1'b0;
  logic       rstn_in = 1'b0;
  eee_req_t   req;
  eee_wake_t  wake = '0;
  logic [7:0] rdata;
  logic       rvalid;
  logic [3:0] np_en;
  logic [15:0] cnt;
  int err_count = 0;
  int n_tests = 0;
  int np = 'hf;
  int n_err = 0;
  logic [7:0] q;
  logic       v;
  logic [7:0] rnd;
  // 10 mhz system clock
  always #50 clk_in = ~clk_in;
  eee_global_indirect_regs eee_global_indirect_regs_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .req_in(req), .wake_in(wake), .rdata_out(rdata), .rvalid_out(rvalid),
    .np_exchange_en_out(np_en), .wake_err_cnt_out(cnt));
  eee_host_model eee_host_model_i (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .req_out(req));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : check
  // expected byte of the global group, from the register layout
  function automatic int exp_byte(input int o);
    case (o)
      'h34: return 'h68;
      'h35: return np;
      'h38: return 'h02;
      'h39, 'h3b: return 'h01;
      default: return 0;
    endcase
  endfunction : exp_byte
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #(100 * 5000);
    err_count++;
    close_out();
  end
  initial begin
    rnd = 8'($urandom(32'h44deade4));
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    #1;
    check(16'(np_en), 16'hf, "reset enables");
    check(cnt, 16'h0, "reset count");
    check(16'(rvalid), 16'h0, "reset valid");
    // direct registers keep all bits; unmapped addresses read zero
    for (int k = 0; k < 4; k++) begin
      rnd = 8'($urandom);
      eee_host_model_i.op(1'b1, 1'b0, EEE_ADDR_TBL_SEL, rnd, q, v);
      check(16'(v), 16'h0, "write answered");
      eee_host_model_i.op(1'b0, 1'b1, EEE_ADDR_TBL_SEL, 8'h00, q, v);
      check(16'(q), {8'h00, rnd}, "select readback");
      eee_host_model_i.op(1'b1, 1'b0, EEE_ADDR_OFFSET, ~rnd, q, v);
      eee_host_model_i.op(1'b0, 1'b1, EEE_ADDR_OFFSET, 8'h00, q, v);
      check(16'(q), {8'h00, ~rnd}, "offset readback");
      eee_host_model_i.op(1'b0, 1'b1, 8'h00, 8'h00, q, v);
      check(16'(q), 16'h0, "unmapped read");
    end
    $display("test readback done");
    // writes everywhere, only the enable byte may take; bit 4 of select is free
    for (int k = 0; k < 2; k++) begin
      for (int o = 'h34; o <= 'h3b; o++) begin
        rnd = 8'($urandom);
        eee_host_model_i.sel(k ? 8'h30 : 8'h20, 8'(o));
        eee_host_model_i.op(1'b1, 1'b0, EEE_ADDR_DATA, rnd, q, v);
        if (o == 'h35) np = rnd[3:0];
        check(16'(np_en), 16'(np), "enables");
        check(16'(v), 16'h0, "write answered");
        eee_host_model_i.op(1'b0, 1'b1, EEE_ADDR_DATA, 8'h00, q, v);
        check(16'(v), 16'h1, "read valid");
        check(16'(q), 16'(exp_byte(o)), "byte");
      end
    end
    $display("test global bytes done");
    // per-port group and a foreign table: data port is dead
    for (int k = 0; k < 2; k++) begin
      eee_host_model_i.sel(k ? 8'h40 : 8'h23, 8'h35);
      eee_host_model_i.op(1'b1, 1'b0, EEE_ADDR_DATA, 8'(~np), q, v);
      eee_host_model_i.op(1'b0, 1'b1, EEE_ADDR_DATA, 8'h00, q, v);
      check(16'(q), 16'h0, "other group read");
      check(16'(np_en), 16'(np), "other group write");
    end
    $display("test group select done");
    // wake events around the threshold, boundary first
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_in);
      wake <= '{done: (i < 2) || $urandom % 2,
                dur: i == 0 ? 16'h0201 : i == 1 ? 16'h0202 : 16'h01f0 + 16'($urandom % 32)};
      #1;
      if (wake.done && wake.dur > 16'h0201) n_err++;
      @(posedge clk_in);
      wake <= '0;
      #1;
      check(cnt, 16'(n_err), "wake errors");
    end
    $display("test wake errors done");
    close_out();
  end
endmodule : testbench
